// [pwm0_event_flags.sv]
// Event flags, enables and interrupt request of PWM unit 0
`timescale 1ns/1ps

// Contract
// - Set overtake flag, bit 7, while counter is at or above shadow limit.
// - Software writing one to overtake flag sets it.
// - Only software clears overtake flag, by writing zero.
// - Overtake flag requests interrupt only while enable bit 3 is set.
// - Compare match sets toggle flag: bit 6 module 2, 5 module 1, 4 module 0.
// - Software writing one to a toggle flag sets it.
// - Toggle flags stay set until software writes zero.
// - Toggle flag reaches interrupt only when enabled: bit 2, 1, 0.
// - Reset clears all eight control register bits.
// - Each of three compare modules has its own flag and enable pair.
// - Match is counter becoming equal or above module compare value.
// - Overtake reloads counter with zero and sets the overtake flag.
module pwm0_event_flags
   import pwm0_event_pkg::*;
(
   input  wire logic              sys_clk_i,
   input  wire logic              nrst_i,
   input  wire bus_req_type       bus_req_i,
   output logic [DATA_W-1:0]      rdata_o,
   input  wire counter_view_type  cnt_i,
   output logic                   counter_reload_o,
   output logic [NUM_MOD-1:0]     match_pulse_o,
   output logic                   irq_o
);

   // ***************************************************************
   // State
   // ***************************************************************
   state_type st_reg;
   state_type st_next;

   // ***************************************************************
   // Event detection
   // ***************************************************************
   logic                overtake_hit;
   logic [NUM_MOD-1:0]  match_now;
   logic [NUM_MOD-1:0]  match_evt;
   logic [DATA_W-1:0]   hw_set;
   logic [EVT_W-1:0]    evt_vec;

   // Counter and compare values come from the same clock, no synchroniser
   assign overtake_hit = cnt_i.run
                         && (cnt_i.count >= cnt_i.limit);

   // Same cycle as the flag, so the counter restarts at zero next edge
   assign counter_reload_o = overtake_hit;

   always_comb
   begin
      for (int n = 0; n < NUM_MOD; n++)
      begin
         match_now[n] = cnt_i.run
                        && (cnt_i.count >= cnt_i.compare[n]);
         // A level held across a reload still counts again in the new period
         match_evt[n] = match_now[n]
                        && (!st_reg.match_level[n]
                            || st_reg.reload_seen);
      end
   end

   assign match_pulse_o = match_evt;

   // ***************************************************************
   // Hardware set vector, laid out like the control register
   // ***************************************************************
   always_comb
   begin
      hw_set = IRQ_CTRL_RESET;
      hw_set[OVERTAKE_FLAG_BIT] = overtake_hit;
      for (int n = 0; n < NUM_MOD; n++)
      begin
         hw_set[MOD_FLAG_BASE + n] = match_evt[n];
      end
   end

   always_comb
   begin
      evt_vec = EVT_STATUS_RESET;
      evt_vec[EVT_OVERTAKE_BIT] = overtake_hit;
      for (int n = 0; n < NUM_MOD; n++)
      begin
         evt_vec[EVT_MOD_BASE + n] = match_evt[n];
      end
   end

   // ***************************************************************
   // Register decode
   // ***************************************************************
   logic ctrl_wr;
   logic status_wr;
   logic mask_wr;

   assign ctrl_wr   = bus_req_i.wr && (bus_req_i.addr == IRQ_CTRL_ADDR);
   assign status_wr = bus_req_i.wr && (bus_req_i.addr == EVT_STATUS_ADDR);
   assign mask_wr   = bus_req_i.wr && (bus_req_i.addr == EVT_MASK_ADDR);

   // ***************************************************************
   // Sticky flag cells
   // ***************************************************************
   // Laid out like the status register: bit 3 overtake, bits 2..0 modules
   logic [EVT_W-1:0] ctrl_flag_next;
   logic [EVT_W-1:0] evt_flag_next;

   // Control flags, the written value replaces the flag
   sticky_flag_cell #(.CLEAR_ON_ONE(1'b0)) overtake_flag_cell_inst
   (
      .flag_i   (st_reg.irq_ctrl[OVERTAKE_FLAG_BIT]),
      .wr_i     (ctrl_wr),
      .wdata_i  (bus_req_i.wdata[OVERTAKE_FLAG_BIT]),
      .hw_set_i (hw_set[OVERTAKE_FLAG_BIT]),
      .flag_o   (ctrl_flag_next[EVT_OVERTAKE_BIT])
   );

   sticky_flag_cell #(.CLEAR_ON_ONE(1'b0)) module2_flag_cell_inst
   (
      .flag_i   (st_reg.irq_ctrl[MOD_FLAG_BASE + 2]),
      .wr_i     (ctrl_wr),
      .wdata_i  (bus_req_i.wdata[MOD_FLAG_BASE + 2]),
      .hw_set_i (hw_set[MOD_FLAG_BASE + 2]),
      .flag_o   (ctrl_flag_next[EVT_MOD_BASE + 2])
   );

   sticky_flag_cell #(.CLEAR_ON_ONE(1'b0)) module1_flag_cell_inst
   (
      .flag_i   (st_reg.irq_ctrl[MOD_FLAG_BASE + 1]),
      .wr_i     (ctrl_wr),
      .wdata_i  (bus_req_i.wdata[MOD_FLAG_BASE + 1]),
      .hw_set_i (hw_set[MOD_FLAG_BASE + 1]),
      .flag_o   (ctrl_flag_next[EVT_MOD_BASE + 1])
   );

   sticky_flag_cell #(.CLEAR_ON_ONE(1'b0)) module0_flag_cell_inst
   (
      .flag_i   (st_reg.irq_ctrl[MOD_FLAG_BASE]),
      .wr_i     (ctrl_wr),
      .wdata_i  (bus_req_i.wdata[MOD_FLAG_BASE]),
      .hw_set_i (hw_set[MOD_FLAG_BASE]),
      .flag_o   (ctrl_flag_next[EVT_MOD_BASE])
   );

   // Status flags, a written one clears
   sticky_flag_cell #(.CLEAR_ON_ONE(1'b1)) overtake_evt_cell_inst
   (
      .flag_i   (st_reg.evt_status[EVT_OVERTAKE_BIT]),
      .wr_i     (status_wr),
      .wdata_i  (bus_req_i.wdata[EVT_OVERTAKE_BIT]),
      .hw_set_i (evt_vec[EVT_OVERTAKE_BIT]),
      .flag_o   (evt_flag_next[EVT_OVERTAKE_BIT])
   );

   sticky_flag_cell #(.CLEAR_ON_ONE(1'b1)) module2_evt_cell_inst
   (
      .flag_i   (st_reg.evt_status[EVT_MOD_BASE + 2]),
      .wr_i     (status_wr),
      .wdata_i  (bus_req_i.wdata[EVT_MOD_BASE + 2]),
      .hw_set_i (evt_vec[EVT_MOD_BASE + 2]),
      .flag_o   (evt_flag_next[EVT_MOD_BASE + 2])
   );

   sticky_flag_cell #(.CLEAR_ON_ONE(1'b1)) module1_evt_cell_inst
   (
      .flag_i   (st_reg.evt_status[EVT_MOD_BASE + 1]),
      .wr_i     (status_wr),
      .wdata_i  (bus_req_i.wdata[EVT_MOD_BASE + 1]),
      .hw_set_i (evt_vec[EVT_MOD_BASE + 1]),
      .flag_o   (evt_flag_next[EVT_MOD_BASE + 1])
   );

   sticky_flag_cell #(.CLEAR_ON_ONE(1'b1)) module0_evt_cell_inst
   (
      .flag_i   (st_reg.evt_status[EVT_MOD_BASE]),
      .wr_i     (status_wr),
      .wdata_i  (bus_req_i.wdata[EVT_MOD_BASE]),
      .hw_set_i (evt_vec[EVT_MOD_BASE]),
      .flag_o   (evt_flag_next[EVT_MOD_BASE])
   );

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb
   begin
      st_next = st_reg;

      // Flag bits: hardware or software sets, only software clears
      st_next.irq_ctrl[OVERTAKE_FLAG_BIT] = ctrl_flag_next[EVT_OVERTAKE_BIT];
      for (int n = 0; n < NUM_MOD; n++)
      begin
         st_next.irq_ctrl[MOD_FLAG_BASE + n] = ctrl_flag_next[EVT_MOD_BASE + n];
      end

      // Enables are plain read/write bits
      if (ctrl_wr)
      begin
         st_next.irq_ctrl[OVERTAKE_EN_BIT] =
            bus_req_i.wdata[OVERTAKE_EN_BIT];
         for (int n = 0; n < NUM_MOD; n++)
         begin
            st_next.irq_ctrl[MOD_EN_BASE + n] =
               bus_req_i.wdata[MOD_EN_BASE + n];
         end
      end

      // Event status: sticky, write one to clear, new event wins
      st_next.evt_status = evt_flag_next;

      if (mask_wr)
      begin
         st_next.evt_mask = bus_req_i.wdata[EVT_W-1:0];
      end

      // Match history for the edge detector
      st_next.match_level = match_now;
      st_next.reload_seen = overtake_hit;

      // Read data stands only in the cycle after the strobe
      st_next.rdata = READ_IDLE;
      if (bus_req_i.rd)
      begin
         case (bus_req_i.addr)
            IRQ_CTRL_ADDR:
            begin
               st_next.rdata = st_reg.irq_ctrl;
            end
            EVT_STATUS_ADDR:
            begin
               st_next.rdata = {{(DATA_W-EVT_W){1'b0}},
                                st_reg.evt_status};
            end
            EVT_MASK_ADDR:
            begin
               st_next.rdata = {{(DATA_W-EVT_W){1'b0}},
                                st_reg.evt_mask};
            end
            default:
            begin
               st_next.rdata = READ_IDLE;
            end
         endcase
      end
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         st_reg.irq_ctrl    <= IRQ_CTRL_RESET;
         st_reg.evt_status  <= EVT_STATUS_RESET;
         st_reg.evt_mask    <= EVT_MASK_RESET;
         st_reg.match_level <= '0;
         st_reg.reload_seen <= 1'b0;
         st_reg.rdata       <= READ_IDLE;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ***************************************************************
   // Interrupt request
   // ***************************************************************
   // Field views, named like the register bits
   logic overtake_flag;
   logic module2_toggle_flag;
   logic module1_toggle_flag;
   logic module0_toggle_flag;
   logic overtake_irq_enable;
   logic module2_irq_enable;
   logic module1_irq_enable;
   logic module0_irq_enable;
   logic ctrl_req;
   logic evt_req;

   assign overtake_flag       = st_reg.irq_ctrl[OVERTAKE_FLAG_BIT];
   assign module2_toggle_flag = st_reg.irq_ctrl[MOD_FLAG_BASE + 2];
   assign module1_toggle_flag = st_reg.irq_ctrl[MOD_FLAG_BASE + 1];
   assign module0_toggle_flag = st_reg.irq_ctrl[MOD_FLAG_BASE];
   assign overtake_irq_enable = st_reg.irq_ctrl[OVERTAKE_EN_BIT];
   assign module2_irq_enable  = st_reg.irq_ctrl[MOD_EN_BASE + 2];
   assign module1_irq_enable  = st_reg.irq_ctrl[MOD_EN_BASE + 1];
   assign module0_irq_enable  = st_reg.irq_ctrl[MOD_EN_BASE];

   // Level request, stays high until software clears the flag
   assign ctrl_req = (overtake_flag && overtake_irq_enable)
                     || (module2_toggle_flag && module2_irq_enable)
                     || (module1_toggle_flag && module1_irq_enable)
                     || (module0_toggle_flag && module0_irq_enable);

   // Mask resets to zero, so by default only the control register drives it
   assign evt_req = |(st_reg.evt_status & st_reg.evt_mask);

   assign irq_o   = ctrl_req || evt_req;
   assign rdata_o = st_reg.rdata;

endmodule : pwm0_event_flags

// ***************************************************************
// Sticky flag cell, shared by control and status flags
// ***************************************************************
// Stateless: the flag itself stays in the owner's state struct
module sticky_flag_cell
   import pwm0_event_pkg::*;
#(
   parameter bit CLEAR_ON_ONE = 1'b0
)
(
   input  wire logic flag_i,
   input  wire logic wr_i,
   input  wire logic wdata_i,
   input  wire logic hw_set_i,
   output logic      flag_o
);

   logic kept;

   // Control flags take the written value, status flags clear on one
   always_comb
   begin
      if (!wr_i)
      begin
         kept = flag_i;
      end
      else if (CLEAR_ON_ONE)
      begin
         kept = flag_i && !wdata_i;
      end
      else
      begin
         kept = wdata_i;
      end
   end

   // Hardware set wins over a clearing write, so no event is lost
   assign flag_o = kept || hw_set_i;

endmodule : sticky_flag_cell

// [pwm0_event_flags_asserts.sv]
// Port checker of the PWM unit 0 event flag block
`timescale 1ns/1ps
module pwm0_event_flags_asserts
   import pwm0_event_pkg::*;
(
   input wire logic               sys_clk_i,
   input wire logic               nrst_i,
   input wire bus_req_type        bus_req_i,
   input wire logic [DATA_W-1:0]  rdata_o,
   input wire counter_view_type   cnt_i,
   input wire logic               counter_reload_o,
   input wire logic [NUM_MOD-1:0] match_pulse_o,
   input wire logic               irq_o
);
   // ********
   // Helpers
   // ********
   logic [NUM_MOD-1:0] ge;
   logic               rd_ctl;
   logic               wr_ctl;
   always_comb
   begin
      for (int n = 0; n < NUM_MOD; n++)
         ge[n] = cnt_i.run && (cnt_i.count >= cnt_i.compare[n]);
   end
   assign rd_ctl = bus_req_i.rd && (bus_req_i.addr == IRQ_CTRL_ADDR);
   assign wr_ctl = bus_req_i.wr && (bus_req_i.addr == IRQ_CTRL_ADDR);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   property p_reload;
      counter_reload_o == (cnt_i.run && cnt_i.count >= cnt_i.limit);
   endproperty
   a_reload: assert property (p_reload)
      else $error("reload not tied to limit");
   property p_mcond;
      (match_pulse_o & ~ge) == 3'h0;
   endproperty
   a_mcond: assert property (p_mcond)
      else $error("match without compare reached");
   property p_mrise;
      $past(cnt_i.run) |-> (match_pulse_o & ge & ~$past(ge)) == (ge & ~$past(ge));
   endproperty
   a_mrise: assert property (p_mrise)
      else $error("compare reached without match");
   property p_ovt;
      counter_reload_o ##1 rd_ctl |=> rdata_o[OVERTAKE_FLAG_BIT];
   endproperty
   a_ovt: assert property (p_ovt)
      else $error("overtake flag not set");
   property p_mflag;
      (|match_pulse_o) ##1 rd_ctl |=> (rdata_o[6:4] & $past(match_pulse_o, 2)) == $past(match_pulse_o, 2);
   endproperty
   a_mflag: assert property (p_mflag)
      else $error("toggle flag not set");
   property p_swset;
      wr_ctl ##1 rd_ctl |=> (rdata_o & $past(bus_req_i.wdata, 2)) == $past(bus_req_i.wdata, 2);
   endproperty
   a_swset: assert property (p_swset)
      else $error("written ones not held");
   property p_sticky;
      rd_ctl ##1 !bus_req_i.wr ##1 rd_ctl |=> (rdata_o[7:4] & $past(rdata_o[7:4], 2)) == $past(rdata_o[7:4], 2);
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("flag cleared without write");
   property p_irq;
      rd_ctl && !counter_reload_o && !(|match_pulse_o) ##1 (|(rdata_o[7:4] & rdata_o[3:0])) |-> irq_o;
   endproperty
   a_irq: assert property (p_irq)
      else $error("enabled flag without interrupt");
endmodule : pwm0_event_flags_asserts
bind pwm0_event_flags pwm0_event_flags_asserts pwm0_event_flags_asserts_inst (
   .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .bus_req_i(bus_req_i), .rdata_o(rdata_o),
   .cnt_i(cnt_i), .counter_reload_o(counter_reload_o), .match_pulse_o(match_pulse_o),
   .irq_o(irq_o));

// [pwm0_event_flags_tb.sv]
// Self-checking bench of the PWM unit 0 event flag block
`timescale 1ns/1ps
module pwm0_event_flags_tb
   import pwm0_event_pkg::*;
;
   logic                          sys_clk_i = 1'b0;
   logic                          nrst_i = 1'b0;
   bus_req_type                   req = '0;
   logic [DATA_W-1:0]             rdata;
   counter_view_type              cnt;
   logic                          reload;
   logic                          irq;
   logic                          run = 1'b0;
   logic                          step = 1'b0;
   logic [CNT_W-1:0]              limit = 16'h0010;
   logic [NUM_MOD-1:0][CNT_W-1:0] cmp = '0;
   logic [31:0]                   rnd = 32'hdb5e4de6;
   logic [7:0]                    en = 8'h00;
   logic [NUM_MOD-1:0]            mpulse;
   logic [NUM_MOD-1:0]            seen = '0;
   int                            fails = 0;
   int                            n_compared = 0;
   int                            cycles = 0;
   always #4 sys_clk_i = ~sys_clk_i;
   pwm_counter_model pwm_counter_model_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
      .run_i(run), .step_i(step), .reload_i(reload), .limit_i(limit), .compare_i(cmp),
      .cnt_o(cnt));
   pwm0_event_flags pwm0_event_flags_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
      .bus_req_i(req), .rdata_o(rdata), .cnt_i(cnt), .counter_reload_o(reload),
      .match_pulse_o(mpulse), .irq_o(irq));
   always @(posedge sys_clk_i)
      seen <= seen | mpulse;
   // ********
   // Helpers
   // ********
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic exp_irq(input logic [7:0] c, input logic [3:0] s, m);
      exp_irq = |(c[7:4] & c[3:0]) | |(s & m);
   endfunction : exp_irq
   task automatic finish_test();
      if (fails == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   task automatic chk_reg(input string nm, input logic [7:0] e, g);
      n_compared++;
      if (g !== e)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_reg
   // Also ends a write, since the strobe is left high for back to back use
   task automatic chk_irq(input logic e);
      req <= '0;
      @(negedge sys_clk_i);
      n_compared++;
      if (irq !== e)
      begin
         fails++;
         $display("MISMATCH irq expected %b seen %b", e, irq);
      end
      @(posedge sys_clk_i);
   endtask : chk_irq
   task automatic wr(input logic [7:0] a, dat);
      req <= '{addr: a, wdata: dat, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk_i);
   endtask : wr
   task automatic rd(input logic [7:0] a, e, input string nm);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk_i);
      req <= '0;
      @(negedge sys_clk_i);
      chk_reg(nm, e, rdata);
      @(posedge sys_clk_i);
   endtask : rd
   always @(posedge sys_clk_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fails++;
         finish_test();
      end
   end
   // ********
   // Sequence
   // ********
   initial
   begin
      repeat (8) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      @(posedge sys_clk_i);
      rd(IRQ_CTRL_ADDR, IRQ_CTRL_RESET, "ctrl");
      rd(EVT_STATUS_ADDR, 8'h00, "status");
      rd(EVT_MASK_ADDR, 8'h00, "mask");
      wr(8'h10, 8'hff);
      rd(8'h10, READ_IDLE, "unmapped");
      rd(IRQ_CTRL_ADDR, 8'h00, "ctrl");
      for (int i = 4; i < 8; i++)
      begin
         rnd = lfsr(rnd);
         en = {4'h0, rnd[3:0]};
         wr(IRQ_CTRL_ADDR, en | (8'h01 << i));
         rd(IRQ_CTRL_ADDR, en | (8'h01 << i), "sw set");
         chk_irq(exp_irq(en | (8'h01 << i), 4'h0, 4'h0));
         wr(IRQ_CTRL_ADDR, en);
         rd(IRQ_CTRL_ADDR, en, "sw clear");
      end
      rnd = lfsr(rnd);
      limit <= 16'h0010 + {11'h000, rnd[4:0]};
      for (int n = 0; n < NUM_MOD; n++)
         cmp[n] <= 16'h0001 + {12'h000, rnd[8+4*n +: 4]};
      run <= 1'b1;
      repeat (600)
      begin
         @(posedge sys_clk_i);
         rnd = lfsr(rnd);
         step <= rnd[0];
      end
      run <= 1'b0;
      rd(IRQ_CTRL_ADDR, 8'hf0 | en, "hw flags");
      rd(EVT_STATUS_ADDR, 8'h0f, "status");
      chk_reg("match pulses", 8'h07, {5'h00, seen});
      chk_irq(exp_irq(8'hf0 | en, 4'hf, 4'h0));
      wr(IRQ_CTRL_ADDR, 8'h00);
      wr(EVT_MASK_ADDR, 8'h04);
      chk_irq(exp_irq(8'h00, 4'hf, 4'h4));
      wr(EVT_STATUS_ADDR, 8'h04);
      chk_irq(exp_irq(8'h00, 4'hb, 4'h4));
      rd(EVT_STATUS_ADDR, 8'h0b, "status clear");
      limit <= 16'h0000;
      cmp <= '0;
      run <= 1'b1;
      step <= 1'b1;
      wr(IRQ_CTRL_ADDR, 8'h00);
      rd(IRQ_CTRL_ADDR, 8'hf0, "hw wins");
      run <= 1'b0;
      finish_test();
   end
endmodule : pwm0_event_flags_tb

// [pwm0_event_pkg.sv]
// Constants and carrier types for the PWM unit 0 event flag block
package pwm0_event_pkg;

   // ***************************************************************
   // Widths
   // ***************************************************************
   localparam int DATA_W  = 8;
   localparam int ADDR_W  = 8;
   localparam int CNT_W   = 16;
   localparam int NUM_MOD = 3;
   localparam int EVT_W   = 4;

   // ***************************************************************
   // Register offsets
   // ***************************************************************
   localparam logic [ADDR_W-1:0] IRQ_CTRL_ADDR   = 8'hee;
   localparam logic [ADDR_W-1:0] EVT_STATUS_ADDR = 8'he6;
   localparam logic [ADDR_W-1:0] EVT_MASK_ADDR   = 8'he7;

   // ***************************************************************
   // Field positions of the interrupt control register
   // ***************************************************************
   localparam int OVERTAKE_FLAG_BIT = 7;
   localparam int MOD_FLAG_BASE     = 4;
   localparam int OVERTAKE_EN_BIT   = 3;
   localparam int MOD_EN_BASE       = 0;

   // ***************************************************************
   // Field positions of the event status and mask registers
   // ***************************************************************
   localparam int EVT_OVERTAKE_BIT = 3;
   localparam int EVT_MOD_BASE     = 0;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [DATA_W-1:0] IRQ_CTRL_RESET   = 8'h00;
   localparam logic [EVT_W-1:0]  EVT_STATUS_RESET = 4'h0;
   localparam logic [EVT_W-1:0]  EVT_MASK_RESET   = 4'h0;
   localparam logic [DATA_W-1:0] READ_IDLE        = 8'h00;

   // ***************************************************************
   // Carrier types
   // ***************************************************************
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } bus_req_type;

   typedef struct packed {
      logic                          run;
      logic [CNT_W-1:0]              count;
      logic [CNT_W-1:0]              limit;
      logic [NUM_MOD-1:0][CNT_W-1:0] compare;
   } counter_view_type;

   typedef struct packed {
      logic [DATA_W-1:0]  irq_ctrl;
      logic [EVT_W-1:0]   evt_status;
      logic [EVT_W-1:0]   evt_mask;
      logic [NUM_MOD-1:0] match_level;
      logic               reload_seen;
      logic [DATA_W-1:0]  rdata;
   } state_type;

endpackage : pwm0_event_pkg

// [pwm_counter_model.sv]
// Behavioural PWM counter on the far side of the flag block
`timescale 1ns/1ps
module pwm_counter_model
   import pwm0_event_pkg::*;
(
   input  wire logic                          sys_clk_i,
   input  wire logic                          nrst_i,
   input  wire logic                          run_i,
   input  wire logic                          step_i,
   input  wire logic                          reload_i,
   input  wire logic [CNT_W-1:0]              limit_i,
   input  wire logic [NUM_MOD-1:0][CNT_W-1:0] compare_i,
   output counter_view_type                   cnt_o
);
   logic [CNT_W-1:0] count_reg;
   // Low step_i stalls, as a slow count source would
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         count_reg <= 16'h0000;
      else if (reload_i)
         count_reg <= 16'h0000;
      else if (run_i && step_i)
         count_reg <= count_reg + 16'h0001;
   end
   assign cnt_o = '{run: run_i, count: count_reg, limit: limit_i, compare: compare_i};
endmodule : pwm_counter_model
